//--- logic/crw_defs.svh
// register offsets, field positions, reset values and widths of the block
`ifndef CRW_DEFS_SVH
`define CRW_DEFS_SVH
`define CRW_OFS_CH1_RESULT_LOW 6'h08
`define CRW_OFS_CH1_RESULT_HIGH 6'h09
`define CRW_OFS_CH2_RESULT_LOW 6'h0A
`define CRW_OFS_CH2_RESULT_HIGH 6'h0B
`define CRW_OFS_CH1_ABS_THR 6'h0C
`define CRW_OFS_CH1_RATE_THR 6'h0D
`define CRW_OFS_CH2_ABS_THR 6'h0E
`define CRW_OFS_CH2_RATE_THR 6'h0F
`define CRW_OFS_CH1_WAKE_CONTROL 6'h20
`define CRW_OFS_CH2_WAKE_CONTROL 6'h21
`define CRW_OFS_STANDBY_CONTROL 6'h22
`define CRW_OFS_WAKE_STATUS 6'h23
`define CRW_BIT_ABS_ENABLE 0
`define CRW_BIT_RATE_ENABLE 1
`define CRW_BIT_COMBINE 2
`define CRW_BIT_OVERRANGE 0
`define CRW_RST_RESULT 8'h00
`define CRW_RST_THRESHOLD 8'h00
`define CRW_RST_WAKE_CONTROL 8'h04
`define CRW_RESULT_W 12
`endif

//--- logic/crw_pkg.sv
// types shared by the block's modules
package crw_pkg;
  typedef logic [11:0] crw_result_type;
  typedef logic [7:0] crw_byte_type;
  typedef enum logic [1:0]
  {
    CRW_ST_IDLE = 2'b01,
    CRW_ST_RESP = 2'b10
  } crw_bus_state_type;
endpackage

//--- logic/crw_chan_if.sv
// per-channel link between register file and wake-up comparator
`timescale 1ns/100ps
interface crw_chan_if;
  logic [11:0] result;
  logic [11:0] prev_result;
  logic sample;
  logic [7:0] abs_thr;
  logic [7:0] rate_thr;
  logic abs_en;
  logic rate_en;
  logic combine;
  logic standby;
  logic wake;
  modport regs
  (
    output result, prev_result, sample, abs_thr, rate_thr,
    output abs_en, rate_en, combine, standby,
    input wake
  );
  modport cmp
  (
    input result, prev_result, sample, abs_thr, rate_thr,
    input abs_en, rate_en, combine, standby,
    output wake
  );
endinterface // crw_chan_if

//--- logic/crw_wake_cmp.sv
// per-channel standby wake-up comparator
`timescale 1ns/100ps
module crw_wake_cmp
  import crw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  crw_chan_if.cmp ch
);
  crw_result_type abs_lim;
  crw_result_type rate_lim;
  crw_result_type delta;
  logic abs_hit;
  logic rate_hit;
  logic wake_q;

  // threshold sits on result bits 11:4, low nibble zero
  assign abs_lim = {ch.abs_thr, 4'h0};
  assign rate_lim = {ch.rate_thr, 4'h0};
  // magnitude of change since the previous conversion
  assign delta = (ch.result >= ch.prev_result) ?
    12'(ch.result - ch.prev_result) : 12'(ch.prev_result - ch.result);
  // a disabled threshold plays no part in the decision
  assign abs_hit = ch.abs_en && (ch.result > abs_lim);
  assign rate_hit = ch.rate_en && (delta > rate_lim);

  always_ff @(posedge clk)
  begin
    if (srst)
      wake_q <= 1'b0;
    else if (ch.sample && ch.standby)
    begin
      if (ch.combine && ch.abs_en && ch.rate_en)
        wake_q <= abs_hit && rate_hit;
      else
        wake_q <= abs_hit || rate_hit;
    end
    else
      wake_q <= 1'b0;
  end

  assign ch.wake = wake_q;
endmodule // crw_wake_cmp

//--- logic/crw_regs.sv
// two-channel conversion result and wake-up threshold registers
// How it works
// - ch1 high result reads result bits 11:4.
// - ch2 high result reads result bits 11:4.
// - ch2 low result holds result bits 3:0 in bits 7:4.
// - overrange flag bit 0 set when conversion overranges.
// - overrange flag cleared when conversion in range, every conversion.
// - result registers are read-only; writes ignored.
// - reserved bits of low result registers read zero.
// - result registers clear to zero on reset.
// - four thresholds read/write, cleared on reset.
// - standby: ch1 result above absolute threshold raises wake.
// - standby: ch1 change above rate threshold raises wake.
// - standby: ch2 result above absolute threshold raises wake.
// - standby: ch2 change above rate threshold raises wake.
// - disabled absolute detection ignores its threshold.
// - disabled rate detection ignores its threshold.
// - enable bits turn each detection on at one.
// - combine one needs both thresholds when both are enabled, else the enabled one; zero needs either.
// - ch1 low: flag bit 0, zeros 3:1, result 3:0 at 7:4.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "crw_defs.svh"
module crw_regs
  import crw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ch1_conv_valid,
  input wire logic [11:0] ch1_conv_result,
  input wire logic ch1_conv_overrange,
  input wire logic ch2_conv_valid,
  input wire logic [11:0] ch2_conv_result,
  input wire logic ch2_conv_overrange,
  input wire logic standby_in,
  output logic ch1_wake,
  output logic ch2_wake,
  output logic standby_q
);
  crw_chan_if ch1_if();
  crw_chan_if ch2_if();

  crw_bus_state_type bus_state_q;
  crw_result_type ch1_result_q;
  crw_result_type ch2_result_q;
  crw_result_type ch1_prev_q;
  crw_result_type ch2_prev_q;
  logic ch1_ovr_q;
  logic ch2_ovr_q;
  logic ch1_sample_q;
  logic ch2_sample_q;
  crw_byte_type ch1_abs_thr_q;
  crw_byte_type ch1_rate_thr_q;
  crw_byte_type ch2_abs_thr_q;
  crw_byte_type ch2_rate_thr_q;
  logic [2:0] ch1_wake_ctl_q;
  logic [2:0] ch2_wake_ctl_q;
  logic [1:0] wake_seen_q;
  logic standby_sw_q;
  logic ch1_wake_q;
  logic ch2_wake_q;
  crw_byte_type rdata_d;
  crw_byte_type rdata_q;
  logic wr_go;
  logic [1:0] wake_clr;
  logic wait_q;

  // bus answers one cycle after the request is seen
  always_ff @(posedge clk)
  begin
    if (srst)
      bus_state_q <= CRW_ST_IDLE;
    else
    begin
      unique case (bus_state_q)
        CRW_ST_IDLE:
          if (avs_read || avs_write)
            bus_state_q <= CRW_ST_RESP;
        CRW_ST_RESP:
          bus_state_q <= CRW_ST_IDLE;
        default:
          bus_state_q <= CRW_ST_IDLE;
      endcase
    end
  end

  assign wr_go = avs_write && (bus_state_q == CRW_ST_RESP);
  // waitrequest is low exactly while the bus state sits in response
  always_ff @(posedge clk)
  begin
    if (srst)
      wait_q <= 1'b1;
    else
      wait_q <= !((bus_state_q == CRW_ST_IDLE) &&
        (avs_read || avs_write));
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // conversion capture: high, low and flag from one conversion
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ch1_result_q <= 12'h000;
      ch1_ovr_q <= 1'b0;
      ch1_prev_q <= 12'h000;
      ch1_sample_q <= 1'b0;
    end
    else
    begin
      ch1_sample_q <= ch1_conv_valid;
      if (ch1_conv_valid)
      begin
        ch1_prev_q <= ch1_result_q;
        ch1_result_q <= ch1_conv_result;
        ch1_ovr_q <= ch1_conv_overrange;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ch2_result_q <= 12'h000;
      ch2_ovr_q <= 1'b0;
      ch2_prev_q <= 12'h000;
      ch2_sample_q <= 1'b0;
    end
    else
    begin
      ch2_sample_q <= ch2_conv_valid;
      if (ch2_conv_valid)
      begin
        ch2_prev_q <= ch2_result_q;
        ch2_result_q <= ch2_conv_result;
        ch2_ovr_q <= ch2_conv_overrange;
      end
    end
  end

  // writable registers; result offsets have no write path
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ch1_abs_thr_q <= `CRW_RST_THRESHOLD;
      ch1_rate_thr_q <= `CRW_RST_THRESHOLD;
      ch2_abs_thr_q <= `CRW_RST_THRESHOLD;
      ch2_rate_thr_q <= `CRW_RST_THRESHOLD;
      ch1_wake_ctl_q <= 3'(`CRW_RST_WAKE_CONTROL);
      ch2_wake_ctl_q <= 3'(`CRW_RST_WAKE_CONTROL);
      standby_sw_q <= 1'b0;
    end
    else if (wr_go)
    begin
      unique case (avs_address)
        `CRW_OFS_CH1_ABS_THR: ch1_abs_thr_q <= avs_writedata;
        `CRW_OFS_CH1_RATE_THR: ch1_rate_thr_q <= avs_writedata;
        `CRW_OFS_CH2_ABS_THR: ch2_abs_thr_q <= avs_writedata;
        `CRW_OFS_CH2_RATE_THR: ch2_rate_thr_q <= avs_writedata;
        `CRW_OFS_CH1_WAKE_CONTROL: ch1_wake_ctl_q <= avs_writedata[2:0];
        `CRW_OFS_CH2_WAKE_CONTROL: ch2_wake_ctl_q <= avs_writedata[2:0];
        `CRW_OFS_STANDBY_CONTROL: standby_sw_q <= avs_writedata[0];
        default: ;
      endcase
    end
  end

  // sticky wake status, write one to clear; a new event wins
  assign wake_clr = (wr_go && avs_address == `CRW_OFS_WAKE_STATUS) ?
    avs_writedata[1:0] : 2'b00;

  always_ff @(posedge clk)
  begin
    if (srst)
      wake_seen_q <= 2'b00;
    else
      wake_seen_q <= (wake_seen_q & ~wake_clr) |
        {ch2_if.wake, ch1_if.wake};
  end

  // pins into standby come from outside: two-stage synchroniser
  logic standby_meta_q;
  logic standby_sync_q;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      standby_meta_q <= 1'b0;
      standby_sync_q <= 1'b0;
      standby_q <= 1'b0;
    end
    else
    begin
      standby_meta_q <= standby_in;
      standby_sync_q <= standby_meta_q;
      standby_q <= standby_sync_q || standby_sw_q;
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    unique case (avs_address)
      `CRW_OFS_CH1_RESULT_LOW:
        rdata_d = {ch1_result_q[3:0], 3'h0, ch1_ovr_q};
      `CRW_OFS_CH1_RESULT_HIGH:
        rdata_d = ch1_result_q[11:4];
      `CRW_OFS_CH2_RESULT_LOW:
        rdata_d = {ch2_result_q[3:0], 3'h0, ch2_ovr_q};
      `CRW_OFS_CH2_RESULT_HIGH:
        rdata_d = ch2_result_q[11:4];
      `CRW_OFS_CH1_ABS_THR: rdata_d = ch1_abs_thr_q;
      `CRW_OFS_CH1_RATE_THR: rdata_d = ch1_rate_thr_q;
      `CRW_OFS_CH2_ABS_THR: rdata_d = ch2_abs_thr_q;
      `CRW_OFS_CH2_RATE_THR: rdata_d = ch2_rate_thr_q;
      `CRW_OFS_CH1_WAKE_CONTROL: rdata_d = {5'h00, ch1_wake_ctl_q};
      `CRW_OFS_CH2_WAKE_CONTROL: rdata_d = {5'h00, ch2_wake_ctl_q};
      `CRW_OFS_STANDBY_CONTROL: rdata_d = {7'h00, standby_sw_q};
      `CRW_OFS_WAKE_STATUS: rdata_d = {5'h00, standby_q, wake_seen_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_q <= 8'h00;
    else if (avs_read && bus_state_q == CRW_ST_IDLE)
      rdata_q <= rdata_d;
  end

  assign ch1_if.result = ch1_result_q;
  assign ch1_if.prev_result = ch1_prev_q;
  assign ch1_if.sample = ch1_sample_q;
  assign ch1_if.abs_thr = ch1_abs_thr_q;
  assign ch1_if.rate_thr = ch1_rate_thr_q;
  assign ch1_if.abs_en = ch1_wake_ctl_q[`CRW_BIT_ABS_ENABLE];
  assign ch1_if.rate_en = ch1_wake_ctl_q[`CRW_BIT_RATE_ENABLE];
  assign ch1_if.combine = ch1_wake_ctl_q[`CRW_BIT_COMBINE];
  assign ch1_if.standby = standby_q;
  assign ch2_if.result = ch2_result_q;
  assign ch2_if.prev_result = ch2_prev_q;
  assign ch2_if.sample = ch2_sample_q;
  assign ch2_if.abs_thr = ch2_abs_thr_q;
  assign ch2_if.rate_thr = ch2_rate_thr_q;
  assign ch2_if.abs_en = ch2_wake_ctl_q[`CRW_BIT_ABS_ENABLE];
  assign ch2_if.rate_en = ch2_wake_ctl_q[`CRW_BIT_RATE_ENABLE];
  assign ch2_if.combine = ch2_wake_ctl_q[`CRW_BIT_COMBINE];
  assign ch2_if.standby = standby_q;

  crw_wake_cmp u_ch1_cmp
  (
    .clk(clk),
    .srst(srst),
    .ch(ch1_if)
  );

  crw_wake_cmp u_ch2_cmp
  (
    .clk(clk),
    .srst(srst),
    .ch(ch2_if)
  );

  // wake outputs registered once more at the top
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ch1_wake_q <= 1'b0;
      ch2_wake_q <= 1'b0;
    end
    else
    begin
      ch1_wake_q <= ch1_if.wake;
      ch2_wake_q <= ch2_if.wake;
    end
  end

  assign ch1_wake = ch1_wake_q;
  assign ch2_wake = ch2_wake_q;
endmodule // crw_regs

//--- tb/crw_conv_model.sv
// converter stand-in delivering one conversion per request
`timescale 1ns/100ps
module crw_conv_model
(
  input wire logic clk,
  input wire logic go,
  input wire logic [11:0] value,
  input wire logic ovr,
  output logic valid,
  output logic [11:0] result,
  output logic overrange
);
  // outside a conversion the data lines do not hold their last value
  always_ff @(posedge clk)
  begin
    valid <= go;
    result <= go ? value : ~result;
    overrange <= go ? ovr : ~overrange;
  end
endmodule // crw_conv_model

//--- tb/crw_regs_assertions.sv
// checker for bus timing, readback and wake timing of the register block
`timescale 1ns/100ps
module crw_regs_chk
  import crw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ch1_conv_valid,
  input wire logic [11:0] ch1_conv_result,
  input wire logic ch1_conv_overrange,
  input wire logic ch2_conv_valid,
  input wire logic [11:0] ch2_conv_result,
  input wire logic ch2_conv_overrange,
  input wire logic standby_in,
  input wire logic ch1_wake,
  input wire logic ch2_wake,
  input wire logic standby_q
);
  logic [11:0] r1_q;
  logic [11:0] r2_q;
  logic o1_q;
  logic o2_q;
  logic [7:0] thr_q [4];
  logic rd_ok;
  assign rd_ok = avs_read && !avs_waitrequest;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r1_q <= 12'h000;
      r2_q <= 12'h000;
      o1_q <= 1'b0;
      o2_q <= 1'b0;
    end
    else
    begin
      if (ch1_conv_valid)
        {r1_q, o1_q} <= {ch1_conv_result, ch1_conv_overrange};
      if (ch2_conv_valid)
        {r2_q, o2_q} <= {ch2_conv_result, ch2_conv_overrange};
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      thr_q <= '{default: 8'h00};
    else if (avs_write && !avs_waitrequest && avs_address[5:2] == 4'h3)
      thr_q[avs_address[1:0]] <= avs_writedata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  reset_clear_a: assert property (
    $fell(srst) |-> avs_readdata == 8'h00 && !ch1_wake && !ch2_wake)
    else $error("state not cleared by reset");
  wait_once_a: assert property (
    (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  ch1_high_a: assert property (
    rd_ok && avs_address == 6'h09 |-> avs_readdata == r1_q[11:4])
    else $error("ch1 high result wrong");
  ch1_low_a: assert property (
    rd_ok && avs_address == 6'h08
    |-> avs_readdata == {r1_q[3:0], 3'b000, o1_q})
    else $error("ch1 low result wrong");
  ch2_high_a: assert property (
    rd_ok && avs_address == 6'h0B |-> avs_readdata == r2_q[11:4])
    else $error("ch2 high result wrong");
  ch2_low_a: assert property (
    rd_ok && avs_address == 6'h0A
    |-> avs_readdata == {r2_q[3:0], 3'b000, o2_q})
    else $error("ch2 low result wrong");
  thr_read_a: assert property (
    rd_ok && avs_address[5:2] == 4'h3
    |-> avs_readdata == thr_q[avs_address[1:0]])
    else $error("threshold readback wrong");
  wake1_src_a: assert property (
    ch1_wake |-> $past(ch1_conv_valid, 2) || $past(ch1_conv_valid, 3))
    else $error("ch1 wake without conversion");
  wake2_src_a: assert property (
    ch2_wake |-> $past(ch2_conv_valid, 2) || $past(ch2_conv_valid, 3))
    else $error("ch2 wake without conversion");
  cover property (rd_ok && avs_address == 6'h08);
  cover property (ch1_wake);
  cover property (ch2_wake);
endmodule // crw_regs_chk
bind crw_regs crw_regs_chk i_chk (.clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .ch1_conv_valid, .ch1_conv_result, .ch1_conv_overrange, .ch2_conv_valid,
  .ch2_conv_result, .ch2_conv_overrange, .standby_in, .ch1_wake,
  .ch2_wake, .standby_q);

//--- tb/testbench.sv
// self-checking bench for the result and wake-up register block
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic ch1_conv_valid, ch1_conv_overrange, ch2_conv_valid, ch2_conv_overrange;
  logic [11:0] ch1_conv_result;
  logic [11:0] ch2_conv_result;
  logic standby_in = 1'b0;
  logic ch1_wake, ch2_wake, standby_q;
  logic go1 = 1'b0;
  logic go2 = 1'b0;
  logic [11:0] cv = 12'h000;
  logic co = 1'b0;
  logic [7:0] rdat;
  int err_count = 0;
  int tests_run = 0;
  int w1 = 0;
  int w2 = 0;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    w1 <= w1 + (ch1_wake === 1'b1);
    w2 <= w2 + (ch2_wake === 1'b1);
  end
  crw_regs i_dut (.clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ch1_conv_valid,
    .ch1_conv_result, .ch1_conv_overrange, .ch2_conv_valid, .ch2_conv_result,
    .ch2_conv_overrange, .standby_in, .ch1_wake, .ch2_wake, .standby_q);
  crw_conv_model i_cv1 (.clk, .go(go1), .value(cv), .ovr(co),
    .valid(ch1_conv_valid), .result(ch1_conv_result),
    .overrange(ch1_conv_overrange));
  crw_conv_model i_cv2 (.clk, .go(go2), .value(cv), .ovr(co),
    .valid(ch2_conv_valid), .result(ch2_conv_result),
    .overrange(ch2_conv_overrange));
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) chk(8'h00, 8'hFF);
    @(posedge clk);
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask
  task conv(input int ch, input logic [11:0] v, input logic o, input int ex);
    int w;
    w = ch == 1 ? w1 : w2;
    cv <= v;
    co <= o;
    go1 <= ch == 1;
    go2 <= ch == 2;
    @(posedge clk);
    go1 <= 1'b0;
    go2 <= 1'b0;
    repeat (6) @(posedge clk);
    chk(8'((ch == 1 ? w1 : w2) - w), 8'(ex));
  endtask
  task t_reset;
    for (int a = 8; a < 16; a++)
      rd(6'(a), 8'h00);
    rd(6'h20, 8'h04);
    rd(6'h21, 8'h04);
    $display("reset values done");
  endtask
  task t_result;
    conv(1, 12'hABC, 1'b1, 0);
    conv(2, 12'h5D3, 1'b0, 0);
    rd(6'h09, 8'hAB);
    rd(6'h08, 8'hC1);
    rd(6'h0B, 8'h5D);
    rd(6'h0A, 8'h30);
    xfer(1'b1, 6'h09, 8'hFF);
    xfer(1'b1, 6'h0A, 8'hFF);
    rd(6'h09, 8'hAB);
    rd(6'h0A, 8'h30);
    conv(1, 12'h123, 1'b0, 0);
    rd(6'h08, 8'h30);
    conv(2, 12'hFFF, 1'b1, 0);
    rd(6'h0A, 8'hF1);
    $display("result registers done");
  endtask
  task t_thr;
    for (int a = 12; a < 16; a++)
      xfer(1'b1, 6'(a), 8'(a * 17));
    xfer(1'b1, 6'h3F, 8'h55);
    for (int a = 12; a < 16; a++)
      rd(6'(a), 8'(a * 17));
    rd(6'h3F, 8'h00);
    $display("threshold registers done");
  endtask
  task t_wake;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(6'h09, 8'h00);
    xfer(1'b1, 6'h22, 8'h01);
    xfer(1'b1, 6'h0C, 8'h80);
    xfer(1'b1, 6'h0D, 8'h10);
    xfer(1'b1, 6'h20, 8'h01);
    conv(1, 12'h800, 1'b0, 0);
    conv(1, 12'h801, 1'b0, 1);
    xfer(1'b1, 6'h20, 8'h00);
    conv(1, 12'hFFF, 1'b0, 0);
    xfer(1'b1, 6'h20, 8'h02);
    conv(1, 12'hEFF, 1'b0, 0);
    conv(1, 12'hDFE, 1'b0, 1);
    xfer(1'b1, 6'h20, 8'h07);
    conv(1, 12'hDFD, 1'b0, 0);
    conv(1, 12'h900, 1'b0, 1);
    xfer(1'b1, 6'h20, 8'h03);
    conv(1, 12'h8FF, 1'b0, 1);
    rd(6'h23, 8'h05);
    xfer(1'b1, 6'h23, 8'h01);
    rd(6'h23, 8'h04);
    xfer(1'b1, 6'h22, 8'h00);
    conv(1, 12'hFFF, 1'b0, 0);
    standby_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, standby_q}, 8'h01);
    conv(1, 12'h000, 1'b0, 1);
    xfer(1'b1, 6'h0E, 8'h20);
    xfer(1'b1, 6'h21, 8'h01);
    conv(2, 12'h201, 1'b0, 1);
    xfer(1'b1, 6'h0F, 8'h01);
    xfer(1'b1, 6'h21, 8'h02);
    conv(2, 12'h212, 1'b0, 1);
    conv(2, 12'h220, 1'b0, 0);
    rd(6'h23, 8'h07);
    standby_in <= 1'b0;
    $display("wake-up detection done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_result();
    t_thr();
    t_wake();
    summarize();
  end
endmodule // testbench
